/* File: pkg/hdc_pkg.sv */
// Package for the headset detection configuration register block.
// Assumes one clock domain and a plain strobe register port.
package hdc_pkg;
    // ==========================================
    // Register map
    localparam logic [7:0] HDC_CFG1_OFFSET = 8'h1A;
    localparam logic [7:0] HDC_CFG1_RESET = 8'h00;
    localparam logic [7:0] HDC_CFG1_WMASK = 8'hFE;
    // ==========================================
    // Field positions
    localparam int HDC_EN_BIT = 1;
    localparam int HDC_CUR_BIT = 2;
    localparam int HDC_CPL_BIT = 3;
    localparam int HDC_INS_LO = 4;
    localparam int HDC_INS_HI = 5;
    localparam int HDC_MIC_BIT = 6;
    localparam int HDC_RSV7_BIT = 7;
    // ==========================================
    // Impedance figures in ohms
    localparam logic [11:0] HDC_MIC_MIN_LO = 12'h320;
    localparam logic [11:0] HDC_MIC_MIN_HI_AC = 12'h546;
    localparam logic [11:0] HDC_MIC_MIN_HI_DC = 12'h6D6;
    localparam logic [11:0] HDC_HOOK_MAX_LO_AC = 12'h140;
    localparam logic [11:0] HDC_HOOK_MAX_LO_DC = 12'h096;
    localparam logic [11:0] HDC_HOOK_MAX_HI = 12'h2A8;
    localparam logic [11:0] HDC_INS_HOOK_0 = 12'h096;
    localparam logic [11:0] HDC_INS_HOOK_1 = 12'h064;
    localparam logic [11:0] HDC_INS_HOOK_2 = 12'h032;
endpackage

/* File: hw/hdc_threshold_map.sv */
// Maps threshold selectors to impedance limits in ohms.
// Assumes registered configuration bits at its inputs.
`timescale 1ns/1ps
module hdc_threshold_map (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Configuration
    input wire logic mic_hook_threshold_select,
    input wire logic dc_coupled,
    input wire logic [1:0] hook_pressed_insert_threshold,
    input wire logic external_resistor_type_setting,
    // Limits
    output logic [11:0] mic_min_ohm,
    output logic [11:0] hook_max_ohm,
    output logic [11:0] insert_hook_min_ohm,
    output logic insert_valid
);
    typedef struct packed {
        logic [11:0] mic;
        logic [11:0] hook;
        logic [11:0] ins;
        logic vld;
    } hdc_map_t;
    hdc_map_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (mic_hook_threshold_select) begin
            st_nxt.hook = hdc_pkg::HDC_HOOK_MAX_HI;
            st_nxt.mic = dc_coupled ? hdc_pkg::HDC_MIC_MIN_HI_DC : hdc_pkg::HDC_MIC_MIN_HI_AC;
        end else begin
            st_nxt.mic = hdc_pkg::HDC_MIC_MIN_LO;
            st_nxt.hook = dc_coupled ? hdc_pkg::HDC_HOOK_MAX_LO_DC : hdc_pkg::HDC_HOOK_MAX_LO_AC;
        end
        // Field only counts with resistor type 0; code 3 gives no limit
        st_nxt.vld = !external_resistor_type_setting && hook_pressed_insert_threshold != 2'h3;
        case (hook_pressed_insert_threshold)
            2'h0: st_nxt.ins = hdc_pkg::HDC_INS_HOOK_0;
            2'h1: st_nxt.ins = hdc_pkg::HDC_INS_HOOK_1;
            2'h2: st_nxt.ins = hdc_pkg::HDC_INS_HOOK_2;
            default: st_nxt.ins = 12'h000;
        endcase
        if (!st_nxt.vld) begin
            st_nxt.ins = 12'h000;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mic_min_ohm = st_r.mic;
    assign hook_max_ohm = st_r.hook;
    assign insert_hook_min_ohm = st_r.ins;
    assign insert_valid = st_r.vld;

    a_ins_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
        external_resistor_type_setting |=> !insert_valid && insert_hook_min_ohm == 12'h000)
        else $error("insert limit active with resistor type 1");
    a_hook_dc_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!mic_hook_threshold_select && dc_coupled) |=> hook_max_ohm == hdc_pkg::HDC_HOOK_MAX_LO_DC)
        else $error("hook limit wrong for low select dc");
    a_mic_dc_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mic_hook_threshold_select && dc_coupled) |=> mic_min_ohm == hdc_pkg::HDC_MIC_MIN_HI_DC)
        else $error("mic limit wrong for high select dc");
endmodule

/* File: hw/hdc_config_reg.sv */
// Headset detection configuration register, one byte, with decoded controls.
// Assumes a single-cycle strobe register port and synchronous inputs.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module hdc_config_reg (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Detection context
    input wire logic EXTERNAL_RESISTOR_TYPE_SETTING,
    // Detection controls
    output logic HEADSET_DETECTION_ENABLE,
    output logic HEADPHONE_COUPLING_SELECT,
    output logic DOUBLE_DETECT_CURRENT_ENABLE,
    output logic MIC_HOOK_THRESHOLD_SELECT,
    output logic [1:0] HOOK_PRESSED_INSERT_THRESHOLD,
    // Decoded limits
    output logic [11:0] MIC_MIN_OHM,
    output logic [11:0] HOOK_MAX_OHM,
    output logic [11:0] INSERT_HOOK_MIN_OHM,
    output logic INSERT_VALID
);
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] rdata;
    } hdc_state_t;
    hdc_state_t st_r, st_nxt;
    logic hit;

    assign hit = ADDR == hdc_pkg::HDC_CFG1_OFFSET;

    // ==========================================
    // Register storage and read path
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 8'h00;
        if (WR && hit) begin
            // Bit 0 is read-only and always reads zero
            st_nxt.cfg = WDATA & hdc_pkg::HDC_CFG1_WMASK;
        end
        if (RD && hit) begin
            st_nxt.rdata = st_r.cfg;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_r <= {hdc_pkg::HDC_CFG1_RESET, 8'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================
    // Control outputs
    assign RDATA = st_r.rdata;
    assign HEADSET_DETECTION_ENABLE = st_r.cfg[hdc_pkg::HDC_EN_BIT];
    assign HEADPHONE_COUPLING_SELECT = st_r.cfg[hdc_pkg::HDC_CPL_BIT];
    assign DOUBLE_DETECT_CURRENT_ENABLE = st_r.cfg[hdc_pkg::HDC_CUR_BIT];
    assign MIC_HOOK_THRESHOLD_SELECT = st_r.cfg[hdc_pkg::HDC_MIC_BIT];
    assign HOOK_PRESSED_INSERT_THRESHOLD = st_r.cfg[hdc_pkg::HDC_INS_HI:hdc_pkg::HDC_INS_LO];

    // Limits lag the register by one cycle
    hdc_threshold_map u_map (
        .sys_clk(SYS_CLK),
        .rst_n(RSTN),
        .mic_hook_threshold_select(st_r.cfg[hdc_pkg::HDC_MIC_BIT]),
        .dc_coupled(st_r.cfg[hdc_pkg::HDC_CPL_BIT]),
        .hook_pressed_insert_threshold(st_r.cfg[hdc_pkg::HDC_INS_HI:hdc_pkg::HDC_INS_LO]),
        .external_resistor_type_setting(EXTERNAL_RESISTOR_TYPE_SETTING),
        .mic_min_ohm(MIC_MIN_OHM),
        .hook_max_ohm(HOOK_MAX_OHM),
        .insert_hook_min_ohm(INSERT_HOOK_MIN_OHM),
        .insert_valid(INSERT_VALID)
    );

    // ==========================================
    // Register checks
    a_enable_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (WR && hit) |=> HEADSET_DETECTION_ENABLE == $past(WDATA[1]))
        else $error("enable does not follow write");
    a_coupling_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (WR && hit) |=> HEADPHONE_COUPLING_SELECT == $past(WDATA[3]))
        else $error("coupling does not follow write");
    a_current_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (WR && hit) |=> DOUBLE_DETECT_CURRENT_ENABLE == $past(WDATA[2]))
        else $error("current select does not follow write");
    a_mic_sel_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (WR && hit) |=> MIC_HOOK_THRESHOLD_SELECT == $past(WDATA[6]))
        else $error("threshold select does not follow write");
    a_ins_field_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (WR && hit) |=> HOOK_PRESSED_INSERT_THRESHOLD == $past(WDATA[5:4]))
        else $error("insert field does not follow write");
    a_rsv7_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (WR && hit) |=> st_r.cfg[7] == $past(WDATA[7]))
        else $error("bit 7 does not follow write");
    a_bit0_store: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (WR && hit) |=> st_r.cfg[0] == 1'b0)
        else $error("read-only bit 0 took a write");
    a_hold_no_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        !(WR && hit) |=> $stable(st_r.cfg))
        else $error("register changed without write");
    // No disable here: the register must sit at zero for the whole reset
    a_reset_clear: assert property (@(posedge SYS_CLK)
        !RSTN |-> st_r.cfg == 8'h00 && RDATA == 8'h00)
        else $error("register not clear in reset");

    // ==========================================
    // Read checks
    a_read_back: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (RD && hit) |=> RDATA == $past(st_r.cfg))
        else $error("read data differ from stored value");
    a_bit0_zero: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (RD && hit) |=> RDATA[0] == 1'b0)
        else $error("read-only bit 0 reads one");
    a_read_miss: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (RD && !hit) |=> RDATA == 8'h00)
        else $error("unmapped read returned data");
    a_rdata_idle: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        !RD |=> RDATA == 8'h00)
        else $error("read data stood beyond one cycle");
    a_read_no_effect: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (RD && hit) |=> $stable(st_r.cfg))
        else $error("read changed the register");

    // ==========================================
    // Limit checks
    // Limits trail the register by a cycle, hence the one-cycle implications
    a_limits_reset: assert property (@(posedge SYS_CLK)
        !RSTN |-> MIC_MIN_OHM == 12'h000 && HOOK_MAX_OHM == 12'h000 && !INSERT_VALID)
        else $error("limits not clear in reset");
    a_limits_start: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        $rose(RSTN) |=> MIC_MIN_OHM == hdc_pkg::HDC_MIC_MIN_LO
            && HOOK_MAX_OHM == hdc_pkg::HDC_HOOK_MAX_LO_AC)
        else $error("limits wrong after reset");
    // First cycle after reset is left out: the map is still leaving zero then
    a_limits_hold: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        ($past(RSTN) && $stable(st_r.cfg) && $stable(EXTERNAL_RESISTOR_TYPE_SETTING))
        |=> $stable(MIC_MIN_OHM) && $stable(HOOK_MAX_OHM) && $stable(INSERT_HOOK_MIN_OHM))
        else $error("limits moved without a cause");
    a_mic_low_sel: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (!MIC_HOOK_THRESHOLD_SELECT ##1 !MIC_HOOK_THRESHOLD_SELECT)
        |=> MIC_MIN_OHM == hdc_pkg::HDC_MIC_MIN_LO)
        else $error("mic limit not 800 ohm");
    a_mic_high_ac: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (MIC_HOOK_THRESHOLD_SELECT && !HEADPHONE_COUPLING_SELECT)
        |=> MIC_MIN_OHM == hdc_pkg::HDC_MIC_MIN_HI_AC)
        else $error("mic limit not 1350 ohm");
    a_hook_low_ac: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (!MIC_HOOK_THRESHOLD_SELECT && !HEADPHONE_COUPLING_SELECT)
        |=> HOOK_MAX_OHM == hdc_pkg::HDC_HOOK_MAX_LO_AC)
        else $error("hook limit not 320 ohm");
    a_hook_high_sel: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        MIC_HOOK_THRESHOLD_SELECT |=> HOOK_MAX_OHM == hdc_pkg::HDC_HOOK_MAX_HI)
        else $error("hook limit not 680 ohm");
    a_ins_code0: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (HOOK_PRESSED_INSERT_THRESHOLD == 2'h0 && !EXTERNAL_RESISTOR_TYPE_SETTING)
        |=> INSERT_VALID && INSERT_HOOK_MIN_OHM == hdc_pkg::HDC_INS_HOOK_0)
        else $error("insert limit not 150 ohm");
    a_ins_code1: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (HOOK_PRESSED_INSERT_THRESHOLD == 2'h1 && !EXTERNAL_RESISTOR_TYPE_SETTING)
        |=> INSERT_HOOK_MIN_OHM == hdc_pkg::HDC_INS_HOOK_1)
        else $error("insert limit not 100 ohm");
    a_ins_code2: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (HOOK_PRESSED_INSERT_THRESHOLD == 2'h2 && !EXTERNAL_RESISTOR_TYPE_SETTING)
        |=> INSERT_VALID && INSERT_HOOK_MIN_OHM == hdc_pkg::HDC_INS_HOOK_2)
        else $error("insert limit not 50 ohm");
    a_ins_reserved: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        HOOK_PRESSED_INSERT_THRESHOLD == 2'h3 |=> !INSERT_VALID && INSERT_HOOK_MIN_OHM == 12'h000)
        else $error("reserved insert code gave a limit");
    a_valid_code: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        INSERT_VALID |-> INSERT_HOOK_MIN_OHM != 12'h000)
        else $error("valid insert limit reads zero");

    // ==========================================
    // Coverage
    c_enable_on: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
        !HEADSET_DETECTION_ENABLE ##1 HEADSET_DETECTION_ENABLE);
    c_dc_high: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
        HEADPHONE_COUPLING_SELECT && MIC_HOOK_THRESHOLD_SELECT);
    c_read_hit: cover property (@(posedge SYS_CLK) disable iff (!RSTN) RD && hit);
    c_ins_code2: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
        INSERT_VALID && HOOK_PRESSED_INSERT_THRESHOLD == 2'h2);
    c_ins_reserved: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
        HOOK_PRESSED_INSERT_THRESHOLD == 2'h3 && !EXTERNAL_RESISTOR_TYPE_SETTING);
endmodule

/* File: tb/hdc_config_reg_tb.sv */
// Self-checking bench for the headset detection configuration register.
// Assumes hdc_config_reg at offset 0x1A and a one-cycle strobe register port.
`timescale 1ns/1ps
module headset_detect_config_reg_tb;
    logic sys_clk, rstn, wr, rd, ext, en, cpl, cur, mic, iv;
    logic [7:0] addr, wdata, rdata, m, rnd;
    logic [1:0] ins;
    logic [11:0] mic_o, hook_o, ins_o;
    int errors = 0, compares = 0, cyc = 0;
    hdc_config_reg i_dut (.SYS_CLK(sys_clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .EXTERNAL_RESISTOR_TYPE_SETTING(ext),
        .HEADSET_DETECTION_ENABLE(en), .HEADPHONE_COUPLING_SELECT(cpl),
        .DOUBLE_DETECT_CURRENT_ENABLE(cur), .MIC_HOOK_THRESHOLD_SELECT(mic),
        .HOOK_PRESSED_INSERT_THRESHOLD(ins), .MIC_MIN_OHM(mic_o), .HOOK_MAX_OHM(hook_o),
        .INSERT_HOOK_MIN_OHM(ins_o), .INSERT_VALID(iv));
    // ==========================================
    // Clock, run limit and closing report
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task stop_test();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            stop_test();
        end
    end
    // ==========================================
    // Compares and expectations
    task chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task chk_ohm(input string n, input logic [12:0] e, input logic [12:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // Minimum microphone: 800, 1350 AC, 1750 DC
    function logic [12:0] f_mic(input logic [7:0] r);
        return r[6] ? (r[3] ? 13'h06D6 : 13'h0546) : 13'h0320;
    endfunction
    // Maximum hook: 320 AC, 150 DC, 680
    function logic [12:0] f_hook(input logic [7:0] r);
        return r[6] ? 13'h02A8 : (r[3] ? 13'h0096 : 13'h0140);
    endfunction
    // Valid flag above the 150/100/50 limit
    function logic [12:0] f_ins(input logic [1:0] c, input logic e);
        if (e || c == 2'h3) return 13'h0000;
        return (c == 2'h0) ? 13'h1096 : (c == 2'h1) ? 13'h1064 : 13'h1032;
    endfunction
    // ==========================================
    // Register port tasks
    task wr_reg(input logic [7:0] a, input logic [7:0] d, input logic e);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        ext <= e;
        @(posedge sys_clk);
        wr <= 1'b0;
        if (a == 8'h1A) m = d & 8'hFE;
        #1 chk_byte("ctrl", {2'h0, m[6:1]}, {2'h0, mic, ins, cpl, cur, en});
        @(posedge sys_clk);
        #1 chk_ohm("mic", f_mic(m), {1'b0, mic_o});
        chk_ohm("hook", f_hook(m), {1'b0, hook_o});
        chk_ohm("ins", f_ins(m[5:4], e), {iv, ins_o});
    endtask
    task rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 chk_byte("rdata", e, rdata);
        @(posedge sys_clk);
        #1 chk_byte("rdata_idle", 8'h00, rdata);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        {wr, rd, ext, addr, wdata, m} = '0;
        void'($urandom(32'hA4D27CE4));
        @(posedge sys_clk);
        #1 chk_ohm("rst", 13'h0000, {iv, mic_o | hook_o | ins_o});
        @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk_byte("rst_ctrl", 8'h00, {2'h0, mic, ins, cpl, cur, en});
        chk_ohm("rst_mic", 13'h0320, {1'b0, mic_o});
        rd_reg(8'h1A, 8'h00);
        // Reserved bits 7 and 0 only ever get their reset value
        wr_reg(8'h1A, 8'h7E, 1'b0);
        rd_reg(8'h1A, 8'h7E);
        wr_reg(8'h1B, 8'h00, 1'b0);
        rd_reg(8'h1A, 8'h7E);
        rd_reg(8'h1B, 8'h00);
        // Every select, coupling, insert code and resistor type combination
        for (int i = 0; i < 32; i++) begin
            wr_reg(8'h1A, {1'b0, i[0], i[2:1], i[3], 3'h2}, i[4]);
        end
        // Mid-run reset must clear every field again
        @(posedge sys_clk);
        rstn <= 1'b0;
        @(posedge sys_clk);
        #1 chk_byte("rst2_ctrl", 8'h00, {2'h0, mic, ins, cpl, cur, en});
        chk_ohm("rst2", 13'h0000, {iv, mic_o | hook_o | ins_o});
        @(posedge sys_clk);
        rstn <= 1'b1;
        rd_reg(8'h1A, 8'h00);
        for (int i = 0; i < 40; i++) begin
            rnd = 8'($urandom());
            wr_reg(8'h1A, rnd & 8'h7E, 1'($urandom()));
            rd_reg(8'h1A, m);
        end
        stop_test();
    end
endmodule
